/* src/sink_ctrl_pkg.sv */
// Purpose: shared constants and types of the sink path state control
// Assumes: pclk at 10 MHz, APB register access
// Notes: interval figures are plain defaults, top module may shorten them
// Behaviour
// - valid input supply feeds aux output, regulator off
// - no input, bus present: regulator feeds aux
// - source choice uses UV comparators and levels
// - sink waits for input stable interval
// - bus undervoltage keeps sink path off
// - stable input, bus ok, request: path on
// - stable input takes over seamlessly, no reset
// - input to regulator may take internal reset
// - disabled: path and protections off, UVLO on
// - disabled to sink on aux 0, sink 1, bus ok
// - sink: path on, protections active
// - sink to disabled when both enables 0
// - sink to fault on overvoltage or overtemperature
// - fault entry switches path off
// - fault leaves on enable low or cleared events
// - fault pin low only for voltage/temperature faults
// - grounded input supply: bus-only operation, same states
// - reverse current: path off, no fault, auto re-enable
// - fault held low for hold interval, then released
// - die overtemperature disables path and regulator
package sink_ctrl_pkg;
	localparam int unsigned CLK_MHZ = 10;
	localparam int unsigned INPUT_STABLE_US = 10000;
	localparam int unsigned FAULT_HOLD_US = 5000;
	localparam int unsigned INPUT_STABLE_CYC = INPUT_STABLE_US * CLK_MHZ;
	localparam int unsigned FAULT_HOLD_CYC = FAULT_HOLD_US * CLK_MHZ;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_EVENTS = 8'h08;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [1:0] EVENTS_RST = 2'h0;
	localparam int unsigned CTRL_SINK_BLOCK = 0;
	localparam int unsigned EV_RESET_SEEN = 0;
	localparam int unsigned EV_FAULT_SEEN = 1;

	localparam int unsigned N_PINS = 11;
	localparam int unsigned P_SYS_OK = 0;
	localparam int unsigned P_BUS_OK = 1;
	localparam int unsigned P_SYS_ABOVE = 2;
	localparam int unsigned P_SINK_EN = 3;
	localparam int unsigned P_AUX_EN = 4;
	localparam int unsigned P_OV_GND = 5;
	localparam int unsigned P_OV_EV = 6;
	localparam int unsigned P_PATH_OT = 7;
	localparam int unsigned P_REV = 8;
	localparam int unsigned P_DIE_OT = 9;
	localparam int unsigned P_AUX_LOW = 10;

	typedef enum logic [1:0] {
		ST_DISABLED = 2'b00,
		ST_SINK = 2'b01,
		ST_SINK_FAULT = 2'b10
	} sink_state_type;
endpackage : sink_ctrl_pkg

/* src/pin_sync.sv */
// Purpose: two-flop synchroniser bank for asynchronous pins
// Assumes: each bit is an independent level
// Notes: first stage feeds the second stage only
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_r[i] <= 1'b0;
					q[i] <= 1'b0;
				end else if (ce) begin
					meta_r[i] <= d[i];
					q[i] <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule : pin_sync

/* src/interval_timer.sv */
// Purpose: counts cycles while run is high, flags done at COUNT
// Assumes: run low clears the count at once
// Notes: done is registered and stays high while run stays high
`timescale 1ns/1ps
module interval_timer #(
	parameter int unsigned COUNT = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic run,
	output logic done
);
	localparam int unsigned CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	assign cnt_nxt = !run ? '0 : (cnt_r == LAST) ? cnt_r : cnt_r + 1'b1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			done <= 1'b0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			done <= run && (cnt_nxt == LAST);
		end
	end
endmodule : interval_timer

/* src/sink_path_state_control.sv */
// Purpose: supply selection, sink path state machine and fault pin
// Assumes: comparator levels arrive asynchronously, APB master on pclk
// Notes: ce low freezes everything, the APB slave included
`timescale 1ns/1ps
module sink_path_state_control
	import sink_ctrl_pkg::*;
#(
	parameter int unsigned STABLE_CYC = INPUT_STABLE_CYC,
	parameter int unsigned HOLD_CYC = FAULT_HOLD_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic system_supply_ok,
	input wire logic bus_supply_ok,
	input wire logic system_above_bus,
	input wire logic sink_enable_in,
	input wire logic aux_enable_in,
	input wire logic overvoltage_sense_grounded,
	input wire logic overvoltage_event,
	input wire logic path_over_temperature,
	input wire logic reverse_current_guard,
	input wire logic over_temperature_trip,
	input wire logic aux_supply_low,
	output logic input_supply_switch,
	output logic bus_regulator_en,
	output logic sink_path_on,
	output logic fault_n_out_o,
	output logic fault_n_out_oe,
	output logic internal_reset
);
	// ****************************************
	// pin synchronisation
	// ****************************************
	logic [N_PINS-1:0] pins_raw;
	logic [N_PINS-1:0] pins;

	assign pins_raw = {aux_supply_low, over_temperature_trip, reverse_current_guard,
		path_over_temperature, overvoltage_event, overvoltage_sense_grounded,
		aux_enable_in, sink_enable_in, system_above_bus, bus_supply_ok,
		system_supply_ok};

	pin_sync #(.W(N_PINS)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d(pins_raw),
		.q(pins)
	);

	wire sys_ok = pins[P_SYS_OK];
	wire bus_ok = pins[P_BUS_OK];
	wire sys_above = pins[P_SYS_ABOVE];
	wire aux_en = pins[P_AUX_EN];
	wire ov_gnd = pins[P_OV_GND];
	wire path_ot = pins[P_PATH_OT];
	wire rev = pins[P_REV];
	wire die_ot = pins[P_DIE_OT];
	wire aux_low = pins[P_AUX_LOW];
	// a grounded sense pin means the overvoltage check is off
	wire ov_act = pins[P_OV_EV] && !ov_gnd;

	// ****************************************
	// registers and timers
	// ****************************************
	logic [31:0] ctrl_r;
	logic [1:0] events_r;
	logic [1:0] events_nxt;
	sink_state_type state_r;
	sink_state_type state_nxt;
	logic stable_done;
	logic hold_done;

	wire sink_req = pins[P_SINK_EN] && !ctrl_r[CTRL_SINK_BLOCK];

	// stability count restarts whenever the input supply dips
	interval_timer #(.COUNT(STABLE_CYC)) u_stable (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.run(sys_ok),
		.done(stable_done)
	);

	interval_timer #(.COUNT(HOLD_CYC)) u_hold (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.run(fault_n_out_oe),
		.done(hold_done)
	);

	// ****************************************
	// supply source selection
	// ****************************************
	// stay on input while valid; move back only once stable and higher
	// an idle regulator has nothing to hand over, so a valid input is taken at once
	wire use_input_nxt = sys_ok &&
		(input_supply_switch || !bus_regulator_en || (stable_done && sys_above));
	wire regulator_nxt = !use_input_nxt && bus_ok && !die_ot;
	// sag of the aux rail while on the regulator restarts the control
	wire soft_rst = bus_regulator_en && aux_low;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_supply_switch <= 1'b0;
			bus_regulator_en <= 1'b0;
			internal_reset <= 1'b0;
		end else if (ce) begin
			input_supply_switch <= use_input_nxt;
			bus_regulator_en <= regulator_nxt;
			internal_reset <= soft_rst;
		end
	end

	// ****************************************
	// state machine
	// ****************************************
	// without an input supply there is nothing to wait for
	wire gate_ok = stable_done || !sys_ok;
	wire fault_evt = ov_act || path_ot;
	wire go_sink = !aux_en && sink_req && bus_ok && gate_ok;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_DISABLED: begin
				if (go_sink) begin
					state_nxt = ST_SINK;
				end
			end
			ST_SINK: begin
				if (!aux_en && !sink_req) begin
					state_nxt = ST_DISABLED;
				end else if (fault_evt) begin
					state_nxt = ST_SINK_FAULT;
				end
			end
			ST_SINK_FAULT: begin
				if (!sink_req) begin
					state_nxt = ST_DISABLED;
				end else if (!fault_evt) begin
					state_nxt = ST_SINK;
				end
			end
			default: begin
				state_nxt = ST_DISABLED;
			end
		endcase
		if (soft_rst) begin
			state_nxt = ST_DISABLED;
		end
	end

	// path follows the next state so fault entry opens it at once
	wire path_nxt = (state_nxt == ST_SINK) && bus_ok && !rev && !die_ot && gate_ok;

	// protections are only armed outside the disabled state
	wire fault_cond = (state_r != ST_DISABLED) && fault_evt;
	logic fault_oe_nxt;
	always_comb begin
		fault_oe_nxt = fault_n_out_oe;
		if (soft_rst) begin
			fault_oe_nxt = 1'b0;
		end else if (fault_cond) begin
			fault_oe_nxt = 1'b1;
		end else if (hold_done) begin
			fault_oe_nxt = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_DISABLED;
			sink_path_on <= 1'b0;
			fault_n_out_oe <= 1'b0;
			fault_n_out_o <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			sink_path_on <= path_nxt;
			fault_n_out_oe <= fault_oe_nxt;
			fault_n_out_o <= 1'b0;
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	// one wait state: pready rises in the second access cycle
	wire acc = psel && penable;
	wire fire = acc && pready;
	wire hit_ctrl = paddr == ADDR_CTRL;
	wire hit_status = paddr == ADDR_STATUS;
	wire hit_events = paddr == ADDR_EVENTS;
	wire bad = !(hit_ctrl || hit_status || hit_events) || (pwrite && hit_status);
	wire wr_ctrl = fire && pwrite && hit_ctrl;
	wire wr_events = fire && pwrite && hit_events;

	wire [31:0] status_word = {24'h00_0000, bus_ok, stable_done, bus_regulator_en,
		input_supply_switch, fault_n_out_oe, sink_path_on, state_r};
	wire [31:0] rd_word = hit_ctrl ? ctrl_r :
		hit_status ? status_word :
		hit_events ? {30'h0000_0000, events_r} : 32'h0000_0000;

	// set beats clear when both land in one cycle
	wire [1:0] ev_set = {fault_oe_nxt && !fault_n_out_oe, soft_rst};
	wire [1:0] ev_clr = wr_events ? pwdata[1:0] : 2'h0;
	assign events_nxt = (events_r & ~ev_clr) | ev_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
			events_r <= EVENTS_RST;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			events_r <= events_nxt;
			pready <= acc && !pready;
			pslverr <= acc && !pready && bad;
			prdata <= (acc && !pready && !pwrite) ? rd_word : 32'h0000_0000;
			if (wr_ctrl) begin
				ctrl_r <= {31'h0000_0000, pwdata[CTRL_SINK_BLOCK]};
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_no_overlap;
		!(input_supply_switch && bus_regulator_en);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both supply sources on");

	property p_bus_uv;
		(ce && !bus_ok) |=> !sink_path_on;
	endproperty
	a_bus_uv: assert property (p_bus_uv) else $error("path on under bus undervoltage");

	property p_path_state;
		sink_path_on |-> state_r == ST_SINK;
	endproperty
	a_path_state: assert property (p_path_state) else $error("path on outside sink state");

	property p_stable_gate;
		$rose(sink_path_on) |-> $past(stable_done || !sys_ok);
	endproperty
	a_stable_gate: assert property (p_stable_gate) else $error("path on before input stable");

	property p_rev;
		(ce && rev) |=> !sink_path_on && (!$rose(fault_n_out_oe) || $past(fault_cond));
	endproperty
	a_rev: assert property (p_rev) else $error("reverse current mishandled");

	property p_die_ot;
		(ce && die_ot) |=> !sink_path_on && !bus_regulator_en;
	endproperty
	a_die_ot: assert property (p_die_ot) else $error("die overtemperature ignored");

	property p_to_sink;
		(ce && state_r == ST_DISABLED && go_sink && !soft_rst) |=> state_r == ST_SINK;
	endproperty
	a_to_sink: assert property (p_to_sink) else $error("sink entry missed");

	property p_to_disabled;
		(ce && state_r == ST_SINK && !aux_en && !sink_req) |=> state_r == ST_DISABLED;
	endproperty
	a_to_disabled: assert property (p_to_disabled) else $error("sink exit missed");

	property p_to_fault;
		(ce && state_r == ST_SINK && sink_req && fault_evt && !soft_rst) |=> state_r == ST_SINK_FAULT ##0 !sink_path_on;
	endproperty
	a_to_fault: assert property (p_to_fault) else $error("fault entry missed");

	property p_fault_cause;
		$rose(fault_n_out_oe) |-> $past(fault_cond);
	endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("fault pin without cause");

	property p_fault_hold;
		$fell(fault_n_out_oe) |-> $past(soft_rst || (hold_done && !fault_cond));
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault released early");

	property p_from_fault_off;
		(ce && state_r == ST_SINK_FAULT && !sink_req) |=> state_r == ST_DISABLED;
	endproperty
	a_from_fault_off: assert property (p_from_fault_off) else $error("fault exit to disabled missed");

	property p_from_fault_back;
		(ce && state_r == ST_SINK_FAULT && sink_req && !fault_evt && !soft_rst) |=> state_r == ST_SINK;
	endproperty
	a_from_fault_back: assert property (p_from_fault_back) else $error("fault exit to sink missed");

	// supply source, reset, path and fault pin checks
	property p_input_feed;
		(ce && sys_ok && input_supply_switch) |=> input_supply_switch && !bus_regulator_en;
	endproperty
	a_input_feed: assert property (p_input_feed) else $error("valid input supply dropped");

	property p_regulator_on;
		(ce && !sys_ok && bus_ok && !die_ot) |=> bus_regulator_en && !input_supply_switch;
	endproperty
	a_regulator_on: assert property (p_regulator_on) else $error("regulator not started");

	property p_take_over;
		(ce && bus_regulator_en && sys_ok && stable_done && sys_above) |=> input_supply_switch && !bus_regulator_en;
	endproperty
	a_take_over: assert property (p_take_over) else $error("input supply not taken over");

	property p_no_rst_on_input;
		(ce && input_supply_switch) |=> !internal_reset;
	endproperty
	a_no_rst_on_input: assert property (p_no_rst_on_input) else $error("reset while on input supply");

	property p_soft_rst;
		(ce && bus_regulator_en && aux_low) |=> internal_reset && state_r == ST_DISABLED && !fault_n_out_oe;
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("aux sag not handled");

	property p_path_resume;
		(ce && state_r == ST_SINK && sink_req && !fault_evt && !soft_rst && bus_ok && !rev && !die_ot && gate_ok)
			|=> sink_path_on;
	endproperty
	a_path_resume: assert property (p_path_resume) else $error("path not on in sink state");

	property p_fault_pin;
		(ce && state_r == ST_SINK && sink_req && fault_evt && !soft_rst) |=> fault_n_out_oe;
	endproperty
	a_fault_pin: assert property (p_fault_pin) else $error("fault pin not driven");

	property p_ov_grounded;
		(ce && state_r == ST_SINK && ov_gnd && !path_ot) |=> state_r != ST_SINK_FAULT;
	endproperty
	a_ov_grounded: assert property (p_ov_grounded) else $error("overvoltage acted while grounded");
endmodule : sink_path_state_control

/* tb/pd_ctrl_model.sv */
// Purpose: controller model driving the enable pins
// Assumes: want is a level set by the bench
// Notes: aux enable never rises, so disabled and sink moves stay legal
`timescale 1ns/1ps
module pd_ctrl_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic want,
	output logic sink_enable_in,
	output logic aux_enable_in
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sink_enable_in <= 1'b0;
		end else begin
			sink_enable_in <= want;
		end
	end
	assign aux_enable_in = 1'b0;
endmodule : pd_ctrl_model

/* tb/tb_top.sv */
// Purpose: self-checking bench of the sink path state control
// Assumes: shortened intervals, ce dropped once to check freezing
// Notes: pin effects are judged 6 edges on: 1 model + 2 sync + 1 register, with margin
`timescale 1ns/1ps
module tb_top;
	import sink_ctrl_pkg::*;
	localparam int unsigned SC = 20;
	localparam int unsigned HC = 10;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ce = 1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er;
	logic sys_ok = 0, bus_ok = 0, above = 0, gnd = 0, ov = 0, pot = 0, rev = 0, dot = 0, alow = 0, want = 0;
	logic sen, aen, iss, breg, path, fo, foe, irst;
	// open drain with pull-up
	wire fault_pin = foe ? fo : 1'b1;
	int num_errors = 0, samples_checked = 0;
	sink_path_state_control #(.STABLE_CYC(SC), .HOLD_CYC(HC)) u_dut (
		.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.system_supply_ok(sys_ok), .bus_supply_ok(bus_ok), .system_above_bus(above),
		.sink_enable_in(sen), .aux_enable_in(aen), .overvoltage_sense_grounded(gnd),
		.overvoltage_event(ov), .path_over_temperature(pot), .reverse_current_guard(rev),
		.over_temperature_trip(dot), .aux_supply_low(alow),
		.input_supply_switch(iss), .bus_regulator_en(breg), .sink_path_on(path),
		.fault_n_out_o(fo), .fault_n_out_oe(foe), .internal_reset(irst)
	);
	pd_ctrl_model u_pd (.pclk(pclk), .presetn(presetn), .want(want), .sink_enable_in(sen), .aux_enable_in(aen));
	initial begin
		forever #50 pclk = ~pclk;
	end
	// ****************
	// shared tasks
	// ****************
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// request held until pready is seen high; only the watchdog ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rs(input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & m, e);
	endtask : rs
	// ****************
	// scenarios
	// ****************
	task automatic t_reset;
		cyc(1);
		chk({iss, breg, path, foe, irst}, 32'h0);
		apb(1'b0, ADDR_EVENTS, 32'h0);
		chk(rd, 32'h0);
	endtask : t_reset
	task automatic t_power;
		@(posedge pclk);
		sys_ok <= 1'b1;
		above <= 1'b1;
		bus_ok <= 1'b1;
		want <= 1'b1;
		cyc(6);
		chk({iss, breg, path}, 32'h4);
		cyc(SC);
		chk(path, 1'b1);
		rs(32'h7, 32'h5);
	endtask : t_power
	task automatic t_gates;
		@(posedge pclk);
		bus_ok <= 1'b0;
		cyc(6);
		chk(path, 1'b0);
		@(posedge pclk);
		bus_ok <= 1'b1;
		rev <= 1'b1;
		cyc(6);
		chk({path, foe}, 32'h0);
		@(posedge pclk);
		rev <= 1'b0;
		cyc(6);
		chk(path, 1'b1);
	endtask : t_gates
	task automatic t_ov;
		@(posedge pclk);
		gnd <= 1'b1;
		ov <= 1'b1;
		cyc(6);
		chk({path, foe}, 32'h2);
		@(posedge pclk);
		gnd <= 1'b0;
		cyc(6);
		chk({path, foe, fault_pin}, 32'h2);
		@(posedge pclk);
		ov <= 1'b0;
		cyc(HC - 6);
		chk(foe, 1'b1);
		cyc(12);
		chk({path, foe}, 32'h2);
	endtask : t_ov
	task automatic t_pot;
		@(posedge pclk);
		pot <= 1'b1;
		cyc(6);
		rs(32'h3, 32'h2);
		chk({path, foe}, 32'h1);
		@(posedge pclk);
		want <= 1'b0;
		cyc(6);
		rs(32'h3, 32'h0);
		@(posedge pclk);
		pot <= 1'b0;
		want <= 1'b1;
		cyc(6);
		rs(32'h7, 32'h5);
		@(posedge pclk);
		want <= 1'b0;
		cyc(6);
		rs(32'h7, 32'h0);
		@(posedge pclk);
		want <= 1'b1;
		cyc(6);
	endtask : t_pot
	task automatic t_freeze;
		@(posedge pclk);
		ce <= 1'b0;
		want <= 1'b0;
		cyc(10);
		chk({path, iss}, 32'h3);
		@(posedge pclk);
		ce <= 1'b1;
		cyc(6);
		chk(path, 1'b0);
		@(posedge pclk);
		want <= 1'b1;
		cyc(6);
		chk(path, 1'b1);
	endtask : t_freeze
	task automatic t_dead;
		@(posedge pclk);
		sys_ok <= 1'b0;
		above <= 1'b0;
		cyc(6);
		chk({iss, breg, path}, 32'h3);
		@(posedge pclk);
		dot <= 1'b1;
		cyc(6);
		chk({breg, path}, 32'h0);
		@(posedge pclk);
		dot <= 1'b0;
		cyc(6);
		chk({breg, path}, 32'h3);
		@(posedge pclk);
		alow <= 1'b1;
		cyc(6);
		chk({irst, path}, 32'h2);
		@(posedge pclk);
		alow <= 1'b0;
		sys_ok <= 1'b1;
		above <= 1'b1;
		cyc(6);
		chk({iss, breg, irst}, 32'h2);
		cyc(SC + 4);
		chk({iss, breg, irst}, 32'h4);
	endtask : t_dead
	task automatic t_regs;
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h1);
		cyc(6);
		chk(path, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk({31'h0000_0000, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, ADDR_STATUS, 32'hFF);
		chk(er, 1'b1);
		apb(1'b0, ADDR_EVENTS, 32'h0);
		chk(rd & 32'h3, 32'h3);
		apb(1'b1, ADDR_EVENTS, 32'h3);
		apb(1'b0, ADDR_EVENTS, 32'h0);
		chk(rd, 32'h0);
	endtask : t_regs
	// ****************
	// run control
	// ****************
	task automatic final_report;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_power();
		t_gates();
		t_ov();
		t_pot();
		t_freeze();
		t_dead();
		t_regs();
		final_report();
	end
	initial begin
		#400000;
		num_errors++;
		final_report();
	end
endmodule : tb_top
